// ==== hw/fie_int_enable_bank.sv ====
// The APB slave port was decided locally.
`timescale 1ns/1ps
module fie_int_enable_bank
    import fie_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Fault event pulses from the detectors
    input  wire logic [6:0]  supply_fault_evt,
    input  wire logic [6:0]  boost_fault_evt,
    input  wire logic [2:0]  led_fault_evt,
    // Interrupt pin level
    output logic             fault_irq_n
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Returns {hit, status_kind, bank[1:0]}
    function automatic logic [3:0] fie_decode(input logic [7:0] a);
        logic [3:0] d;
        d = 4'h0;
        unique case (a)
            {FIE_IDX_SUPPLY_EN, 2'b00}: d = 4'h8;
            {FIE_IDX_BOOST_EN,  2'b00}: d = 4'h9;
            {FIE_IDX_LED_EN,    2'b00}: d = 4'ha;
            {FIE_IDX_SUPPLY_ST, 2'b00}: d = 4'hc;
            {FIE_IDX_BOOST_ST,  2'b00}: d = 4'hd;
            {FIE_IDX_LED_ST,    2'b00}: d = 4'he;
            default:                    d = 4'h0;
        endcase
        return d;
    endfunction

    fie_state_t      r;        // Registered state
    fie_state_t      nxt;      // Next state
    logic [3:0]      dec;      // Decode of current address
    logic            wr_acc;   // Write access phase on a mapped register
    logic [2:0][7:0] evt_all;  // Fault events aligned to fields
    logic [1:0]      code;     // Field of write data under update

    assign dec = fie_decode(paddr);
    assign wr_acc = psel && penable && pwrite && dec[3];

    // Boost events start at field 1, field 0 being reserved
    assign evt_all = {{5'h00, led_fault_evt}, {boost_fault_evt, 1'b0}, {1'b0, supply_fault_evt}};

    // ----------------------------------------------------------------
    // Bus answers
    // ----------------------------------------------------------------
    // Zero wait states: read data is prepared in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !dec[3];
    assign prdata  = r.rdata;
    assign fault_irq_n = !r.irq;

    // ----------------------------------------------------------------
    // Named enables per fault source
    // ----------------------------------------------------------------
    // Plain views of the enable state, so checks read by source name
    // Field f of a bank covers register bits 2f+1 down to 2f
    logic sync_clock_missing_irq_en;      // Missing sync clock
    logic charge_pump_irq_en;             // Charge pump fault
    logic pump_capacitor_missing_irq_en;  // Pump capacitor missing
    logic input_overcurrent_irq_en;       // Input over-current
    logic logic_supply_low_irq_en;        // Logic supply under-voltage
    logic input_overvoltage_irq_en;       // Input over-voltage
    logic input_undervoltage_irq_en;      // Input under-voltage
    logic thermal_trip_irq_en;            // Thermal shutdown
    logic current_resistor_short_irq_en;  // Current resistor shorted
    logic string_config_resistor_irq_en;  // String resistor missing
    logic mode_resistor_missing_irq_en;   // Mode resistor missing
    logic freq_resistor_missing_irq_en;   // Frequency resistor missing
    logic converter_overcurrent_irq_en;   // Converter over-current
    logic converter_overvoltage_irq_en;   // Converter over-voltage
    logic global_irq_en;                  // Gate over all sources

    // Supply bank, fields 6 down to 0; field 7 is reserved
    assign sync_clock_missing_irq_en     = r.en[0][6]; // [RQ7]
    assign charge_pump_irq_en            = r.en[0][5]; // [RQ8]
    assign pump_capacitor_missing_irq_en = r.en[0][4]; // [RQ9]
    assign input_overcurrent_irq_en      = r.en[0][3]; // [RQ10]
    assign logic_supply_low_irq_en       = r.en[0][2]; // [RQ11]
    assign input_overvoltage_irq_en      = r.en[0][1]; // [RQ12]
    assign input_undervoltage_irq_en     = r.en[0][0]; // [RQ13]
    // Boost bank; field 0 is reserved and gates nothing
    assign thermal_trip_irq_en           = r.en[1][7]; // [RQ14]
    assign current_resistor_short_irq_en = r.en[1][6]; // [RQ15]
    assign string_config_resistor_irq_en = r.en[1][5]; // [RQ16]
    assign mode_resistor_missing_irq_en  = r.en[1][4]; // [RQ17]
    assign freq_resistor_missing_irq_en  = r.en[1][3]; // [RQ18]
    assign converter_overcurrent_irq_en  = r.en[1][2]; // [RQ19]
    assign converter_overvoltage_irq_en  = r.en[1][1]; // [RQ20]
    // Global gate sits in field 3 of the LED bank
    assign global_irq_en = r.en[FIE_LED_REG][FIE_GLOBAL_FLD]; // [RQ22]

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        nxt = r;
        code = 2'h0;
        // Capture read data in setup so it stands through the access
        if (psel && !penable) begin
            nxt.rdata = '0;
            if (!pwrite && dec[3]) begin
                for (int f = 0; f < FIE_FIELDS; f++) begin
                    // Enabled reads 2h, disabled 0h, never the written code
                    nxt.rdata[2*f+1] = dec[2] ? r.st[dec[1:0]][f] : r.en[dec[1:0]][f]; // [RQ2]
                end
            end
        end
        for (int g = 0; g < 3; g++) begin
            for (int f = 0; f < FIE_FIELDS; f++) begin
                code = pwdata[2*f +: 2];
                if (wr_acc && dec[1:0] == 2'(g) && pstrb[f/4]) begin
                    if (!dec[2] && FIE_EN_MASK[g][f]) begin
                        // Only 3h and 1h act; 0h and 2h leave the field alone
                        if (code == FIE_WR_ENABLE) begin
                            nxt.en[g][f] = 1'b1; // [RQ1] [RQ23]
                        end else if (code == FIE_WR_DISABLE) begin
                            nxt.en[g][f] = 1'b0; // [RQ1] [RQ23]
                        end
                    end
                    // Status and clear bit must both be one in one write
                    if (dec[2] && code == FIE_ST_CLEAR) begin
                        nxt.st[g][f] = 1'b0; // [RQ21]
                    end
                end
                // A new event wins over a clear in the same cycle
                if (evt_all[g][f] && FIE_SRC_MASK[g][f]) begin
                    nxt.st[g][f] = 1'b1;
                end
            end
        end
        // Status is never touched by enables, only masked here
        nxt.irq = nxt.en[FIE_LED_REG][FIE_GLOBAL_FLD] &&
                  |(nxt.st & nxt.en & FIE_SRC_MASK); // [RQ24] [RQ25] [RQ22]
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.en    <= FIE_RST_EN; // [RQ3] [RQ4] [RQ5] [RQ6]
            r.st    <= '0;
            r.rdata <= '0;
            r.irq   <= 1'b0;
        end else begin
            r <= nxt;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    localparam logic [7:0] A_SUP  = {FIE_IDX_SUPPLY_EN, 2'b00};
    localparam logic [7:0] A_BST  = {FIE_IDX_BOOST_EN, 2'b00};
    localparam logic [7:0] A_LED  = {FIE_IDX_LED_EN, 2'b00};
    localparam logic [7:0] A_SUPS = {FIE_IDX_SUPPLY_ST, 2'b00};

    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == a && pstrb == 4'hf;
    endsequence

    sequence s_rd_setup(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    property p_reset_values;
        $rose(presetn) |-> r.en == {8'h0f, 8'hc6, 8'h7f};
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("enable reset values wrong"); // [RQ3]

    property p_enable_code;
        s_wr(A_SUP) ##0 (pwdata[13:12] == 2'h3) |=> r.en[0][6];
    endproperty
    a_enable_code: assert property (p_enable_code) else $error("code 3h did not enable"); // [RQ1]

    property p_disable_code;
        s_wr(A_BST) ##0 (pwdata[15:14] == 2'h1) |=> !r.en[1][7];
    endproperty
    a_disable_code: assert property (p_disable_code) else $error("code 1h did not disable"); // [RQ1]

    property p_harmless_codes;
        s_wr(A_SUP) ##0 (pwdata[1:0] inside {2'h0, 2'h2}) |=> $stable(r.en[0][0]);
    endproperty
    a_harmless_codes: assert property (p_harmless_codes) else $error("0h or 2h changed enable"); // [RQ23]

    property p_readback;
        s_rd_setup(A_SUP) ##1 (psel && penable) |->
            prdata[13:12] == {r.en[0][6], 1'b0} && prdata[15:14] == 2'h0;
    endproperty
    a_readback: assert property (p_readback) else $error("enable read-back code wrong"); // [RQ2]

    property p_reserved_boost;
        s_rd_setup(A_BST) |=> prdata[1:0] == 2'h0 && prdata[31:16] == 16'h0000;
    endproperty
    a_reserved_boost: assert property (p_reserved_boost) else $error("reserved bits not zero"); // [RQ6]

    property p_irq_follows;
        supply_fault_evt[0] && r.en[0][0] && r.en[2][3] |=> !fault_irq_n;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("enabled fault gave no interrupt"); // [RQ24]

    property p_clear;
        s_wr(A_SUPS) ##0 (pwdata[1:0] == 2'h3) && !supply_fault_evt[0] |=> !r.st[0][0];
    endproperty
    a_clear: assert property (p_clear) else $error("status not cleared"); // [RQ21]

    property p_set_wins;
        s_wr(A_SUPS) ##0 (pwdata[1:0] == 2'h3) && supply_fault_evt[0] |=> r.st[0][0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // [RQ21]

    property p_mask_keeps_status;
        s_wr(A_SUP) ##0 !supply_fault_evt[0] |=> $stable(r.st[0][0]);
    endproperty
    a_mask_keeps_status: assert property (p_mask_keeps_status) else $error("enable write hit status"); // [RQ25]

    property p_global_off;
        s_wr(A_LED) ##0 (pwdata[7:6] == 2'h1) |=> fault_irq_n [*2];
    endproperty
    a_global_off: assert property (p_global_off) else $error("global disable left interrupt"); // [RQ22]

    // An event on an enabled source with no write in flight
    // A write in the same cycle may mask it, so it is left out here
    sequence s_gated(logic ev, logic en);
        ev && en && global_irq_en && !wr_acc;
    endsequence

    // Each enabled source reaches the pin one cycle after its event
    // Missing sync clock
    property p_src_sync;
        s_gated(supply_fault_evt[6], sync_clock_missing_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_sync: assert property (p_src_sync) else $error("sync clock fault not gated"); // [RQ7]

    // Charge pump
    property p_src_pump;
        s_gated(supply_fault_evt[5], charge_pump_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_pump: assert property (p_src_pump) else $error("pump fault not gated"); // [RQ8]

    // Pump capacitor
    property p_src_cap;
        s_gated(supply_fault_evt[4], pump_capacitor_missing_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_cap: assert property (p_src_cap) else $error("capacitor fault not gated"); // [RQ9]

    // Input over-current
    property p_src_in_oc;
        s_gated(supply_fault_evt[3], input_overcurrent_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_in_oc: assert property (p_src_in_oc) else $error("input over-current not gated"); // [RQ10]

    // Logic supply low
    property p_src_logic;
        s_gated(supply_fault_evt[2], logic_supply_low_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_logic: assert property (p_src_logic) else $error("logic supply fault not gated"); // [RQ11]

    // Input over-voltage
    property p_src_in_ov;
        s_gated(supply_fault_evt[1], input_overvoltage_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_in_ov: assert property (p_src_in_ov) else $error("input over-voltage not gated"); // [RQ12]

    // Input under-voltage
    property p_src_in_uv;
        s_gated(supply_fault_evt[0], input_undervoltage_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_in_uv: assert property (p_src_in_uv) else $error("input under-voltage not gated"); // [RQ13]

    // Thermal shutdown
    property p_src_thermal;
        s_gated(boost_fault_evt[6], thermal_trip_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_thermal: assert property (p_src_thermal) else $error("thermal event not gated"); // [RQ14]

    // Current resistor short
    property p_src_cur;
        s_gated(boost_fault_evt[5], current_resistor_short_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_cur: assert property (p_src_cur) else $error("current resistor fault not gated"); // [RQ15]

    // String resistor
    property p_src_string;
        s_gated(boost_fault_evt[4], string_config_resistor_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_string: assert property (p_src_string) else $error("string resistor fault not gated"); // [RQ16]

    // Mode resistor
    property p_src_mode;
        s_gated(boost_fault_evt[3], mode_resistor_missing_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_mode: assert property (p_src_mode) else $error("mode resistor fault not gated"); // [RQ17]

    // Frequency resistor
    property p_src_freq;
        s_gated(boost_fault_evt[2], freq_resistor_missing_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_freq: assert property (p_src_freq) else $error("freq resistor fault not gated"); // [RQ18]

    // Converter over-current
    property p_src_conv_oc;
        s_gated(boost_fault_evt[1], converter_overcurrent_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_conv_oc: assert property (p_src_conv_oc) else $error("converter over-current not gated"); // [RQ19]

    // Converter over-voltage
    property p_src_conv_ov;
        s_gated(boost_fault_evt[0], converter_overvoltage_irq_en) |=> !fault_irq_n;
    endproperty
    a_src_conv_ov: assert property (p_src_conv_ov) else $error("converter over-voltage not gated"); // [RQ20]

    // String, mode and frequency resistor checks start masked, they only matter once configured
    property p_reset_off;
        $rose(presetn) |-> !string_config_resistor_irq_en && !mode_resistor_missing_irq_en &&
            !freq_resistor_missing_irq_en;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("resistor enables not off"); // [RQ16] [RQ17] [RQ18]

    // Global gate takes the same enable code as the sources
    property p_global_on;
        s_wr(A_LED) ##0 (pwdata[7:6] == 2'h3) |=> global_irq_en;
    endproperty
    a_global_on: assert property (p_global_on) else $error("global enable code ignored"); // [RQ22]

    // Nothing latched means a quiet pin
    property p_idle_quiet;
        r.st == '0 |-> fault_irq_n;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("interrupt with no status"); // [RQ24]

    // Global gate off means a quiet pin
    property p_global_quiet;
        !global_irq_en |-> fault_irq_n;
    endproperty
    a_global_quiet: assert property (p_global_quiet) else $error("interrupt while globally off"); // [RQ22]

    // Status latches whether or not its enable is set
    property p_status_latch;
        supply_fault_evt[3] |=> r.st[0][3];
    endproperty
    a_status_latch: assert property (p_status_latch) else $error("event not latched"); // [RQ24]

    // Status bit alone must not drop a latched fault
    property p_half_clear;
        s_wr(A_SUPS) ##0 (pwdata[1:0] == 2'h2) && r.st[0][0] |=> r.st[0][0];
    endproperty
    a_half_clear: assert property (p_half_clear) else $error("status cleared by one bit"); // [RQ21]

    // Reserved supply field reads zero
    property p_reserved_supply;
        s_rd_setup(A_SUP) |=> prdata[15:14] == 2'h0;
    endproperty
    a_reserved_supply: assert property (p_reserved_supply) else $error("reserved supply bits set"); // [RQ6]

endmodule

// ==== pkg/fie_pkg.sv ====
// How it works
// RQ1 - Write 3h enables source, 1h disables
// RQ2 - Field reads 2h enabled, 0h disabled
// RQ3 - Supply enables at 08h, reset 2AAAh
// RQ4 - Boost enables at 0Ah, reset A028h
// RQ5 - LED enables at 0Ch, reset AAh
// RQ6 - Reserved fields reset zero, gate nothing
// RQ7 - Supply 13-12 gates missing sync clock
// RQ8 - Supply 11-10 gates charge pump fault
// RQ9 - Supply 9-8 gates missing pump capacitor
// RQ10 - Supply 7-6 gates input over-current
// RQ11 - Supply 5-4 gates logic supply under-voltage
// RQ12 - Supply 3-2 gates input over-voltage
// RQ13 - Supply 1-0 gates input under-voltage
// RQ14 - Boost 15-14 gates thermal shutdown
// RQ15 - Boost 13-12 gates current resistor short
// RQ16 - Boost 11-10 gates string resistor, reset off
// RQ17 - Boost 9-8 gates mode resistor, reset off
// RQ18 - Boost 7-6 gates frequency resistor, reset off
// RQ19 - Boost 5-4 gates converter over-current
// RQ20 - Boost 3-2 gates converter over-voltage
// RQ21 - Fault clears when status and clear written
// RQ22 - LED 7-6 is the global enable
// RQ23 - Writing 0h or 2h changes nothing
// RQ24 - Interrupt only for enabled latched fault
// RQ25 - Enable changes never touch latched status
package fie_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] FIE_IDX_SUPPLY_EN = 6'h08;
    localparam logic [5:0] FIE_IDX_BOOST_EN  = 6'h0a;
    localparam logic [5:0] FIE_IDX_LED_EN    = 6'h0c;
    localparam logic [5:0] FIE_IDX_SUPPLY_ST = 6'h0e;
    localparam logic [5:0] FIE_IDX_BOOST_ST  = 6'h10;
    localparam logic [5:0] FIE_IDX_LED_ST    = 6'h12;

    // ----------------------------------------------------------------
    // Reset values of the enable registers
    // ----------------------------------------------------------------
    localparam logic [15:0] FIE_RST_SUPPLY_EN = 16'h2aaa;
    localparam logic [15:0] FIE_RST_BOOST_EN  = 16'ha028;
    localparam logic [15:0] FIE_RST_LED_EN    = 16'h00aa;

    // ----------------------------------------------------------------
    // Field codes and layout
    // ----------------------------------------------------------------
    localparam logic [1:0] FIE_WR_ENABLE  = 2'h3;  // Write code: enable
    localparam logic [1:0] FIE_WR_DISABLE = 2'h1;  // Write code: disable
    localparam logic [1:0] FIE_ST_CLEAR   = 2'h3;  // Status and clear both one
    localparam int         FIE_FIELDS     = 8;     // Two-bit fields per register
    localparam int         FIE_GLOBAL_FLD = 3;     // Global enable field in LED reg
    localparam int         FIE_LED_REG    = 2;     // Bank index of LED register

    // Fields that hold an enable at all (bank 2,1,0 = LED, boost, supply)
    localparam logic [2:0][7:0] FIE_EN_MASK  = {8'h0f, 8'hfe, 8'h7f};
    // Fields that have a fault source behind them
    localparam logic [2:0][7:0] FIE_SRC_MASK = {8'h07, 8'hfe, 8'h7f};

    // Enable bit per field taken from the high bit of each reset code
    function automatic logic [7:0] fie_rst_bits(input logic [15:0] v);
        logic [7:0] b;
        b = '0;
        for (int f = 0; f < FIE_FIELDS; f++) begin
            b[f] = v[2*f+1];
        end
        return b;
    endfunction

    localparam logic [2:0][7:0] FIE_RST_EN = {fie_rst_bits(FIE_RST_LED_EN),
                                              fie_rst_bits(FIE_RST_BOOST_EN),
                                              fie_rst_bits(FIE_RST_SUPPLY_EN)};

    // ----------------------------------------------------------------
    // State of the bank
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0][7:0] en;     // Enable per field
        logic [2:0][7:0] st;     // Latched fault status per field
        logic [31:0]     rdata;  // Read data held for the access phase
        logic            irq;    // Interrupt asserted
    } fie_state_t;

endpackage

// ==== sim/fault_interrupt_enable_bank_test.sv ====
`timescale 1ns/1ps
module fault_interrupt_enable_bank_test;
    import fie_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_irq_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  pstrb;
    logic [6:0]  supply_fault_evt, boost_fault_evt;
    logic [2:0]  led_fault_evt;
    logic        e;
    logic [7:0]  en_m[3], st_m[3];                      // Model enables and status
    logic [7:0]  enm[3] = '{8'h7f, 8'hfe, 8'h0f};       // Fields with an enable
    logic [7:0]  srcm[3] = '{8'h7f, 8'hfe, 8'h07};      // Fields with a source
    int          n_fail = 0, checks = 0, cyc = 0;

    fie_int_enable_bank uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_fault_evt(supply_fault_evt),
        .boost_fault_evt(boost_fault_evt), .led_fault_evt(led_fault_evt), .fault_irq_n(fault_irq_n));
    fie_host_model host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ---------------------------------------------
    // Clock and hang guard
    // ---------------------------------------------
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks++;
        if (got !== ex) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Model read-back: enable reads 2h/0h, status bit is the high bit of a field
    function automatic logic [31:0] rb(input int k);
        logic [31:0] v;
        v = '0;
        for (int f = 0; f < 8; f++) v[2*f+1] = (k < 3) ? en_m[k][f] : st_m[k-3][f];
        return v;
    endfunction

    // Model of one write; only 3h and 1h codes act, only strobed lanes count
    task automatic mwr(input int k, input logic [31:0] d, input logic [3:0] s);
        for (int f = 0; f < 8; f++) begin
            if (s[f/4] && k < 3 && enm[k][f] && d[2*f+:2] == 2'h3) en_m[k][f] = 1'b1;
            if (s[f/4] && k < 3 && enm[k][f] && d[2*f+:2] == 2'h1) en_m[k][f] = 1'b0;
            if (s[f/4] && k >= 3 && d[2*f+:2] == 2'h3) st_m[k-3][f] = 1'b0;
        end
    endtask

    // Interrupt pin after settling; masked status only, global enable on top
    task automatic chk_irq();
        repeat (2) @(posedge pclk);
        chk("irq_n", !(en_m[2][3] && |((st_m[0] & en_m[0]) | (st_m[1] & en_m[1]) | (st_m[2] & en_m[2] & 8'h07))), fault_irq_n);
    endtask

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial begin
        int k, r;
        logic [31:0] d;
        logic [3:0]  s;
        presetn = 1'b0;
        supply_fault_evt = '0;
        boost_fault_evt = '0;
        led_fault_evt = '0;
        en_m = '{8'h7f, 8'hc6, 8'h0f};
        st_m = '{8'h00, 8'h00, 8'h00};
        void'($urandom(32'h2c99));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values of all six registers
        for (k = 0; k < 6; k++) begin
            host.xfer(8'h20 + 8'(8 * k), 1'b0, '0, '0, q, e);
            chk("reset_rb", rb(k), q);
        end
        chk("reset_supply", 32'h2aaa, rb(0));
        chk("reset_boost", 32'ha028, rb(1));
        chk("reset_led", 32'h00aa, rb(2));
        // Random operations against the model
        for (int i = 0; i < 600; i++) begin
            r = $urandom % 4;
            k = $urandom % 7;
            d = $urandom;
            s = 4'($urandom);
            if (r == 0 || r == 1) begin
                k = (r == 0) ? k % 3 : 3 + k % 3;
                host.xfer(8'h20 + 8'(8 * k), 1'b1, d, s, q, e);
                mwr(k, d, s);
                chk("wr_err", 32'h0, {31'h0, e});
            end else if (r == 2) begin
                @(posedge pclk);
                supply_fault_evt <= 7'(d);
                boost_fault_evt <= 7'(d >> 8);
                led_fault_evt <= 3'(d >> 16);
                @(posedge pclk);
                supply_fault_evt <= '0;
                boost_fault_evt <= '0;
                led_fault_evt <= '0;
                for (int f = 0; f < 7; f++) begin
                    st_m[0][f] |= d[f];
                    st_m[1][f+1] |= d[8+f];
                end
                st_m[2][2:0] |= d[18:16];
            end else begin
                host.xfer((k == 6) ? 8'h24 : 8'h20 + 8'(8 * k), 1'b0, '0, '0, q, e);
                chk("rd_data", (k == 6) ? 32'h0 : rb(k), q);
                chk("rd_err", {31'h0, k == 6}, {31'h0, e});
            end
            chk_irq();
        end
        print_verdict();
    end
endmodule

// ==== sim/fie_host_model.sv ====
`timescale 1ns/1ps
// Host software seen through the APB register port
module fie_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master outputs
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    // APB slave answers
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ---------------------------------------------
    // Idle bus from time zero
    // ---------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
    end

    // One transfer; held until pready is seen high, no fixed latency assumed
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
